/* cfseq_top.v */
/*
  start-up and protection sequencer of a two-phase series-capacitor buck:
  enable, precharge, soft start, run, fault hiccup, power-good drive.
  assumes analog comparators present their results as levels from outside
  the mclk domain; the enable pin is pulled only by open-drain parties.
*/
// Notes on behaviour
// - low-sides stay off until phase A high-side switches
// - high-sides idle until soft-start ramp exceeds feedback
// - power good released inside 95 to 105 window
// - power good low on fault, disable, soft start
// - three consecutive overcurrent hits trip shutdown
// - hiccup restart, interval set by oscillator frequency
// - current limit strap latched at power-up or enable
// - forced continuous mode: complementary, constant frequency
// - feedback outside 90 to 110 trips fault
// - no operation below input undervoltage lockout
// - input overvoltage tristates switches, restarts via soft start
// - enable threshold starts or stops, no hysteresis
// - 1 uA pull-up always, extra 3 uA once enabled
// - precharge series capacitor to half input first
// - series cap under 35 percent faults, full restart
// - series cap over 65 percent faults, bleed path
// - frequency lock and window fault ignored in soft start
// - oscillator strap latched at power-up or enable
`timescale 1ns/1ps
`include "cfseq_defines.vh"
module cfseq_top #(
  parameter HIC_4M_CYC  = `CFSEQ_HIC_4M_CYC,
  parameter HIC_7M_CYC  = `CFSEQ_HIC_7M_CYC,
  parameter HIC_10M_CYC = `CFSEQ_HIC_10M_CYC
) (
  mclk,
  rst_n,
  enable_above_thr,
  vin_above_input_undervolt_lockout,
  vin_above_input_overvolt_lockout_rise,
  vin_below_input_overvolt_lockout_fall,
  cap_precharge_done,
  cap_below_35pct,
  cap_above_65pct,
  ss_ramp_above_fb,
  fb_in_pg_window,
  fb_in_fault_window,
  ss_ramp_done,
  oc_sample_strobe,
  oc_hit_phase_a,
  oc_hit_phase_b,
  phase_a_hs_pulse,
  current_limit_select_strap_open,
  fsel_strap,
  pg_pull_low,
  pg_pull_low_oe,
  hs_enable,
  ls_enable,
  switches_hiz,
  forced_continuous_mode_mode,
  precharge_on,
  softstart_run,
  freq_lock_on,
  bleed_on,
  en_pullup_1ua,
  en_pullup_3ua,
  current_limit_select_15a_sel,
  fsel_latched,
  oc_flag,
  window_fault_flag,
  cap_uv_flag,
  cap_ov_flag,
  input_overvolt_lockout_flag,
  seq_state
);
  input  wire       mclk;
  input  wire       rst_n;
  input  wire       enable_above_thr;
  input  wire       vin_above_input_undervolt_lockout;
  input  wire       vin_above_input_overvolt_lockout_rise;
  input  wire       vin_below_input_overvolt_lockout_fall;
  input  wire       cap_precharge_done;
  input  wire       cap_below_35pct;
  input  wire       cap_above_65pct;
  input  wire       ss_ramp_above_fb;
  input  wire       fb_in_pg_window;
  input  wire       fb_in_fault_window;
  input  wire       ss_ramp_done;
  input  wire       oc_sample_strobe;
  input  wire       oc_hit_phase_a;
  input  wire       oc_hit_phase_b;
  input  wire       phase_a_hs_pulse;
  input  wire       current_limit_select_strap_open;
  input  wire [1:0] fsel_strap;
  output reg        pg_pull_low;
  output reg        pg_pull_low_oe;
  output reg        hs_enable;
  output reg        ls_enable;
  output reg        switches_hiz;
  output reg        forced_continuous_mode_mode;
  output reg        precharge_on;
  output reg        softstart_run;
  output reg        freq_lock_on;
  output reg        bleed_on;
  output reg        en_pullup_1ua;
  output reg        en_pullup_3ua;
  output reg        current_limit_select_15a_sel;
  output reg  [1:0] fsel_latched;
  output reg        oc_flag;
  output reg        window_fault_flag;
  output reg        cap_uv_flag;
  output reg        cap_ov_flag;
  output reg        input_overvolt_lockout_flag;
  output reg  [2:0] seq_state;

  // synchronised comparator levels
  wire [12:0] raw_in;
  wire [12:0] syn;
  assign raw_in = {enable_above_thr, vin_above_input_undervolt_lockout, vin_above_input_overvolt_lockout_rise,
                   vin_below_input_overvolt_lockout_fall, cap_precharge_done, cap_below_35pct,
                   cap_above_65pct, ss_ramp_above_fb, fb_in_pg_window,
                   fb_in_fault_window, ss_ramp_done, oc_sample_strobe,
                   phase_a_hs_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1) begin : g_sync
      cfseq_sync u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (raw_in[gi]),
        .dout  (syn[gi])
      );
    end
  endgenerate

  wire en_s     = syn[12];
  wire input_undervolt_lockout_ok  = syn[11];
  wire input_overvolt_lockout_up  = syn[10];
  wire input_overvolt_lockout_dn  = syn[9];
  wire pc_done  = syn[8];
  wire cap_lo   = syn[7];
  wire cap_hi   = syn[6];
  wire ramp_gt  = syn[5];
  wire pg_win   = syn[4];
  wire flt_win  = syn[3];
  wire ss_done  = syn[2];
  wire oc_stb   = syn[1];
  wire hsa_pls  = syn[0];

  // oc hit lines pass three flops; a hit counts only once stages two and
  // three agree, so a line caught mid-change never adds a false hit
  reg  [2:0] oca_r;
  reg  [2:0] ocb_r;
  reg        oc_stb_d_r;
  wire       oc_sample = oc_stb & ~oc_stb_d_r;

  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [1:0] oc_cnt_r;
  reg  [1:0] oc_cnt_nxt;
  reg  [27:0] hic_cnt_r;
  reg  [27:0] hic_cnt_nxt;
  reg        hsa_seen_r;
  reg        hs_go_r;
  reg        en_d_r;
  reg  [2:0] cause_r;
  reg  [2:0] cause_nxt;

  wire active   = en_s & input_undervolt_lockout_ok;
  wire operate  = (state_r == `CFSEQ_ST_PRECHG) | (state_r == `CFSEQ_ST_SOFT) |
                  (state_r == `CFSEQ_ST_RUN);
  wire oc_trip  = (oc_cnt_nxt == `CFSEQ_OC_HITS);
  wire win_trip = (state_r == `CFSEQ_ST_RUN) & ~flt_win;

  reg [27:0] hic_len;
  always @* begin
    case (fsel_latched)
      `CFSEQ_FSEL_7M:  hic_len = HIC_7M_CYC[27:0];
      `CFSEQ_FSEL_10M: hic_len = HIC_10M_CYC[27:0];
      default:         hic_len = HIC_4M_CYC[27:0];
    endcase
  end

  // overcurrent counter: three consecutive sampled hits in either phase
  always @* begin
    oc_cnt_nxt = oc_cnt_r;
    if (!operate) begin
      oc_cnt_nxt = 2'h0;
    end else if (oc_sample) begin
      if ((oca_r[2] & oca_r[1]) | (ocb_r[2] & ocb_r[1])) begin
        oc_cnt_nxt = oc_cnt_r + 2'h1;
      end else begin
        oc_cnt_nxt = 2'h0;
      end
    end
  end

  always @* begin
    state_nxt   = state_r;
    hic_cnt_nxt = hic_cnt_r;
    cause_nxt   = cause_r;
    if (!active) begin
      state_nxt = `CFSEQ_ST_OFF;
      cause_nxt = `CFSEQ_FLT_NONE;
    end else if (operate & input_overvolt_lockout_up) begin
      state_nxt   = `CFSEQ_ST_HICCUP;
      cause_nxt   = `CFSEQ_FLT_INPUT_OVERVOLT_LOCKOUT;
      hic_cnt_nxt = 28'h0;
    end else if (operate & (oc_trip | win_trip | cap_lo | cap_hi)) begin
      state_nxt   = `CFSEQ_ST_HICCUP;
      hic_cnt_nxt = hic_len;
      if (cap_hi) begin
        cause_nxt = `CFSEQ_FLT_CAPOV;
      end else if (cap_lo) begin
        cause_nxt = `CFSEQ_FLT_CAPUV;
      end else if (oc_trip) begin
        cause_nxt = `CFSEQ_FLT_OC;
      end else begin
        cause_nxt = `CFSEQ_FLT_WIN;
      end
    end else begin
      case (state_r)
        `CFSEQ_ST_OFF: begin
          state_nxt = `CFSEQ_ST_PRECHG;
        end
        `CFSEQ_ST_PRECHG: begin
          if (pc_done) begin
            state_nxt = `CFSEQ_ST_SOFT;
          end
        end
        `CFSEQ_ST_SOFT: begin
          if (ss_done) begin
            state_nxt = `CFSEQ_ST_RUN;
          end
        end
        `CFSEQ_ST_RUN: begin
          state_nxt = `CFSEQ_ST_RUN;
        end
        `CFSEQ_ST_HICCUP: begin
          if (cause_r == `CFSEQ_FLT_INPUT_OVERVOLT_LOCKOUT) begin
            // overvoltage waits for the falling threshold, no hiccup count
            if (input_overvolt_lockout_dn) begin
              state_nxt = `CFSEQ_ST_PRECHG;
              cause_nxt = `CFSEQ_FLT_NONE;
            end
          end else if (hic_cnt_r == 28'h0) begin
            state_nxt = `CFSEQ_ST_PRECHG;
            cause_nxt = `CFSEQ_FLT_NONE;
          end else begin
            hic_cnt_nxt = hic_cnt_r - 28'h1;
          end
        end
        default: begin
          state_nxt = `CFSEQ_ST_OFF;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oca_r      <= 3'h0;
      ocb_r      <= 3'h0;
      oc_stb_d_r <= 1'b0;
      state_r    <= `CFSEQ_ST_OFF;
      oc_cnt_r   <= 2'h0;
      hic_cnt_r  <= 28'h0;
      cause_r    <= `CFSEQ_FLT_NONE;
      hsa_seen_r <= 1'b0;
      hs_go_r    <= 1'b0;
      en_d_r     <= 1'b0;
    end else begin
      oca_r      <= {oca_r[1:0], oc_hit_phase_a};
      ocb_r      <= {ocb_r[1:0], oc_hit_phase_b};
      oc_stb_d_r <= oc_stb;
      state_r    <= state_nxt;
      oc_cnt_r   <= oc_cnt_nxt;
      hic_cnt_r  <= hic_cnt_nxt;
      cause_r    <= cause_nxt;
      en_d_r     <= active;
      if (state_nxt != `CFSEQ_ST_SOFT && state_nxt != `CFSEQ_ST_RUN) begin
        hs_go_r    <= 1'b0;
        hsa_seen_r <= 1'b0;
      end else begin
        if (ramp_gt) begin
          hs_go_r <= 1'b1;
        end
        if (hs_go_r & hsa_pls) begin
          hsa_seen_r <= 1'b1;
        end
      end
    end
  end

  // straps are caught on the edge where the part becomes active, never in reset
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      current_limit_select_15a_sel <= 1'b1;
      fsel_latched <= `CFSEQ_FSEL_4M;
    end else if (active & ~en_d_r) begin
      current_limit_select_15a_sel <= current_limit_select_strap_open;
      fsel_latched <= (fsel_strap == 2'h3) ? `CFSEQ_FSEL_4M : fsel_strap;
    end
  end

  wire run_soft = (state_nxt == `CFSEQ_ST_SOFT) | (state_nxt == `CFSEQ_ST_RUN);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pg_pull_low       <= 1'b0;
      pg_pull_low_oe    <= 1'b1;
      hs_enable         <= 1'b0;
      ls_enable         <= 1'b0;
      switches_hiz      <= 1'b1;
      forced_continuous_mode_mode         <= 1'b0;
      precharge_on      <= 1'b0;
      softstart_run     <= 1'b0;
      freq_lock_on      <= 1'b0;
      bleed_on          <= 1'b0;
      en_pullup_1ua     <= 1'b1;
      en_pullup_3ua     <= 1'b0;
      oc_flag           <= 1'b0;
      window_fault_flag <= 1'b0;
      cap_uv_flag       <= 1'b0;
      cap_ov_flag       <= 1'b0;
      input_overvolt_lockout_flag         <= 1'b0;
      seq_state         <= `CFSEQ_ST_OFF;
    end else begin
      // open-drain: output is always low, enable means pulling down
      pg_pull_low    <= 1'b0;
      pg_pull_low_oe <= ~((state_nxt == `CFSEQ_ST_RUN) & pg_win);
      hs_enable      <= run_soft & (hs_go_r | ramp_gt);
      ls_enable      <= run_soft & (hsa_seen_r | (hs_go_r & hsa_pls));
      switches_hiz   <= ~run_soft;
      forced_continuous_mode_mode      <= run_soft;
      precharge_on   <= (state_nxt == `CFSEQ_ST_PRECHG);
      softstart_run  <= (state_nxt == `CFSEQ_ST_SOFT);
      freq_lock_on   <= (state_nxt == `CFSEQ_ST_RUN);
      bleed_on       <= (state_nxt == `CFSEQ_ST_HICCUP) & (cause_nxt == `CFSEQ_FLT_CAPOV);
      en_pullup_1ua  <= 1'b1;
      en_pullup_3ua  <= en_s;
      oc_flag           <= (cause_nxt == `CFSEQ_FLT_OC);
      window_fault_flag <= (cause_nxt == `CFSEQ_FLT_WIN);
      cap_uv_flag       <= (cause_nxt == `CFSEQ_FLT_CAPUV);
      cap_ov_flag       <= (cause_nxt == `CFSEQ_FLT_CAPOV);
      input_overvolt_lockout_flag         <= (cause_nxt == `CFSEQ_FLT_INPUT_OVERVOLT_LOCKOUT);
      seq_state         <= state_nxt;
    end
  end
endmodule

/* cfseq_defines.vh */
/*
  shared constants of the converter fault sequencer: states, strap codes,
  timing figures and derived cycle counts.
  assumes a 200 MHz mclk; included by its bare name.
*/
`ifndef CFSEQ_DEFINES_VH
`define CFSEQ_DEFINES_VH

`define CFSEQ_CLK_MHZ       200
// sequencer states
`define CFSEQ_ST_OFF        3'h0
`define CFSEQ_ST_PRECHG     3'h1
`define CFSEQ_ST_SOFT       3'h2
`define CFSEQ_ST_RUN        3'h3
`define CFSEQ_ST_HICCUP     3'h4
// oscillator strap codes
`define CFSEQ_FSEL_4M       2'h0
`define CFSEQ_FSEL_7M       2'h1
`define CFSEQ_FSEL_10M      2'h2
// hiccup intervals in microseconds
`define CFSEQ_HIC_4M_US     32800
`define CFSEQ_HIC_7M_US     18700
`define CFSEQ_HIC_10M_US    13100
`define CFSEQ_HIC_4M_CYC    (`CFSEQ_HIC_4M_US * `CFSEQ_CLK_MHZ)
`define CFSEQ_HIC_7M_CYC    (`CFSEQ_HIC_7M_US * `CFSEQ_CLK_MHZ)
`define CFSEQ_HIC_10M_CYC   (`CFSEQ_HIC_10M_US * `CFSEQ_CLK_MHZ)
// overcurrent trip needs this many back to back hits
`define CFSEQ_OC_HITS       2'h3
// fault cause codes
`define CFSEQ_FLT_NONE      3'h0
`define CFSEQ_FLT_OC        3'h1
`define CFSEQ_FLT_WIN       3'h2
`define CFSEQ_FLT_CAPUV     3'h3
`define CFSEQ_FLT_CAPOV     3'h4
`define CFSEQ_FLT_INPUT_OVERVOLT_LOCKOUT      3'h5
`endif

/* cfseq_sync.v */
/*
  three-stage input synchroniser with agreement filter.
  assumes an asynchronous level input; output changes once stages two and
  three agree, stage one feeds stage two only.
*/
`timescale 1ns/1ps
module cfseq_sync (
  mclk,
  rst_n,
  din,
  dout
);
  input  wire mclk;
  input  wire rst_n;
  input  wire din;
  output reg  dout;

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

/* cfseq_monitor.sv */
/* checker of the sequencer top ports: order, switch gating, power good.
   assumes binding into cfseq_top; one clock domain, mclk. */
`timescale 1ns/1ps
module cfseq_monitor (
  input wire       mclk,
  input wire       rst_n,
  input wire       enable_above_thr,
  input wire       vin_above_input_undervolt_lockout,
  input wire       pg_pull_low_oe,
  input wire       hs_enable,
  input wire       ls_enable,
  input wire       switches_hiz,
  input wire       forced_continuous_mode_mode,
  input wire       softstart_run,
  input wire       freq_lock_on,
  input wire       bleed_on,
  input wire       oc_flag,
  input wire       window_fault_flag,
  input wire       cap_uv_flag,
  input wire       cap_ov_flag,
  input wire       input_overvolt_lockout_flag,
  input wire [2:0] seq_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // 8 cycles covers the input synchroniser plus the output register
  sequence s_idle;
    (!(enable_above_thr && vin_above_input_undervolt_lockout)) [*8];
  endsequence
  property p_off; s_idle |-> seq_state == 3'h0 && !hs_enable && !ls_enable; endproperty
  a_off: assert property (p_off) else $error("not off while inactive");
  property p_pg_hold; seq_state != 3'h3 |-> pg_pull_low_oe; endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("pg released outside run");
  property p_ls_gate; ls_enable |-> hs_enable; endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("low side before high side");
  property p_hs_start; $rose(hs_enable) |-> seq_state == 3'h2; endproperty
  a_hs_start: assert property (p_hs_start) else $error("high side outside soft start");
  property p_trip;
    (oc_flag || window_fault_flag || cap_uv_flag) |-> !hs_enable && !ls_enable && pg_pull_low_oe;
  endproperty
  a_trip: assert property (p_trip) else $error("switching during fault");
  property p_bleed; cap_ov_flag |-> bleed_on && !hs_enable && pg_pull_low_oe; endproperty
  a_bleed: assert property (p_bleed) else $error("no bleed on cap overvoltage");
  property p_input_overvolt_lockout; input_overvolt_lockout_flag |-> switches_hiz && pg_pull_low_oe; endproperty
  a_input_overvolt_lockout: assert property (p_input_overvolt_lockout) else $error("switches driven in overvoltage");
  property p_order;
    $changed(seq_state) |-> seq_state == 3'h0 || seq_state == 3'h4 ||
      seq_state == $past(seq_state) + 3'h1 || ($past(seq_state) == 3'h4 && seq_state == 3'h1);
  endproperty
  a_order: assert property (p_order) else $error("state order broken");
  property p_soft; softstart_run |-> !freq_lock_on && pg_pull_low_oe; endproperty
  a_soft: assert property (p_soft) else $error("lock or pg active in soft start");
  property p_run; seq_state == 3'h3 |-> forced_continuous_mode_mode && freq_lock_on; endproperty
  a_run: assert property (p_run) else $error("run without forced_continuous_mode or lock");
endmodule
bind cfseq_top cfseq_monitor u_cfseq_monitor (.*);

/* cfseq_board.sv */
/* board side: open-drain enable driver and power-good pull-up.
   assumes the bench requests enable low through en_pull_low. */
`timescale 1ns/1ps
module cfseq_board (
  input  wire en_pull_low,
  input  wire pg_pull_low,
  input  wire pg_pull_low_oe,
  output wire enable_above_thr,
  output wire pg_good
);
  // only ever pulls low; the pull-up brings the pin high otherwise
  assign enable_above_thr = !en_pull_low;
  // released pin floats up through the board resistor
  assign pg_good = pg_pull_low_oe ? pg_pull_low : 1'b1;
endmodule

/* cfseq_top_tb.sv */
/* self-checking bench of the sequencer with the board model.
   assumes short hiccup counts; straps random from a fixed seed. */
`timescale 1ns/1ps
`define CHK(s, e, g) begin compares++; if ((e) !== (g)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", s, e, g); end end
module cfseq_top_tb;
  logic mclk = 0, rst_n = 0, en_pull_low = 1, vin_above_input_undervolt_lockout = 0, vin_above_input_overvolt_lockout_rise = 0;
  logic vin_below_input_overvolt_lockout_fall = 1, cap_precharge_done = 0, cap_below_35pct = 0;
  logic cap_above_65pct = 0, ss_ramp_above_fb = 0, fb_in_pg_window = 0, ss_ramp_done = 0;
  logic fb_in_fault_window = 1, oc_sample_strobe = 0, oc_hit_phase_a = 0, oc_hit_phase_b = 0;
  logic phase_a_hs_pulse = 0, current_limit_select_strap_open = 0;
  logic [1:0] fsel_strap = 0, f, fl;
  wire enable_above_thr, pg_good, pg_pull_low, pg_pull_low_oe, hs_enable, ls_enable;
  wire switches_hiz, forced_continuous_mode_mode, precharge_on, softstart_run, freq_lock_on, bleed_on;
  wire en_pullup_1ua, en_pullup_3ua, current_limit_select_15a_sel, oc_flag, window_fault_flag;
  wire cap_uv_flag, cap_ov_flag, input_overvolt_lockout_flag;
  wire [1:0] fsel_latched;
  wire [2:0] seq_state;
  int errors = 0, compares = 0, n;
  logic [15:0] rs = 16'hE235;
  int hic_n = 0;
  logic hic_in = 0;
  // counts the cycles of each hiccup stay from 1, whatever the bench was doing then
  always @(posedge mclk) begin
    hic_in <= seq_state === 3'h4;
    if (seq_state === 3'h4) hic_n <= hic_in ? hic_n + 1 : 1;
  end
  cfseq_top #(.HIC_4M_CYC(50), .HIC_7M_CYC(40), .HIC_10M_CYC(30)) u_cfseq_top (.*);
  cfseq_board u_cfseq_board (.*);
  always #2.5 mclk = ~mclk;
  function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 7);
    rs = rs ^ (rs >> 9);
    rs = rs ^ (rs << 8);
    return rs;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wst(input logic [2:0] s);
    n = 0;
    while (seq_state !== s && n < 30) begin
      cyc(1);
      n++;
    end
    `CHK("seq_state", s, seq_state)
  endtask
  task automatic strb(input logic a, input logic b);
    oc_hit_phase_a = a;
    oc_hit_phase_b = b;
    cyc(4);
    oc_sample_strobe = 1;
    cyc(5);
    oc_sample_strobe = 0;
    cyc(5);
  endtask
  task automatic up();
    f = 2'(rnd());
    fl = f == 2'h3 ? 2'h0 : f;
    fsel_strap = f;
    current_limit_select_strap_open = f[0];
    en_pull_low = 0;
    vin_above_input_undervolt_lockout = 1;
    wst(3'h1);
    `CHK("pc_on", 1'b1, precharge_on)
    fsel_strap = ~f;
    current_limit_select_strap_open = ~f[0];
    cap_precharge_done = 1;
    wst(3'h2);
    `CHK("ss_run", 1'b1, softstart_run)
    `CHK("forced_continuous_mode", 1'b1, forced_continuous_mode_mode)
    `CHK("hiz", 1'b0, switches_hiz)
    cyc(8);
    `CHK("hs", 1'b0, hs_enable)
    ss_ramp_above_fb = 1;
    fb_in_fault_window = 0;
    cyc(8);
    `CHK("hs_on", 1'b1, hs_enable)
    `CHK("ls", 1'b0, ls_enable)
    phase_a_hs_pulse = 1;
    cyc(8);
    `CHK("ls_on", 1'b1, ls_enable)
    `CHK("pg", 1'b0, pg_good)
    fb_in_fault_window = 1;
    fb_in_pg_window = 1;
    ss_ramp_done = 1;
    wst(3'h3);
    cyc(6);
    `CHK("pg", 1'b1, pg_good)
    `CHK("lock", 1'b1, freq_lock_on)
    `CHK("pu1", 1'b1, en_pullup_1ua)
    `CHK("pu3", 1'b1, en_pullup_3ua)
    `CHK("fsel", fl, fsel_latched)
    `CHK("current_limit_select", f[0], current_limit_select_15a_sel)
  endtask
  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1;
    `CHK("pg_oe", 1'b1, pg_pull_low_oe)
    for (int i = 0; i < 6; i++) begin
      up();
      fb_in_pg_window = 0;
      cyc(8);
      `CHK("pg_out", 1'b0, pg_good)
      fb_in_pg_window = 1;
      case (i)
        0: begin
          strb(1, 0);
          strb(0, 1);
          strb(0, 0);
          strb(1, 1);
          strb(1, 0);
          `CHK("oc_early", 1'b0, oc_flag)
          strb(0, 1);
        end
        1: fb_in_fault_window = 0;
        2: cap_below_35pct = 1;
        3: cap_above_65pct = 1;
        4: begin
          vin_above_input_overvolt_lockout_rise = 1;
          vin_below_input_overvolt_lockout_fall = 0;
        end
        default: cap_below_35pct = 1;
      endcase
      wst(3'h4);
      if (i < 5) `CHK("flags", 5'h10 >> i, {oc_flag, window_fault_flag, cap_uv_flag, cap_ov_flag, input_overvolt_lockout_flag})
      `CHK("bleed", i == 3, bleed_on)
      {cap_below_35pct, cap_above_65pct, fb_in_fault_window} = 3'h1;
      {cap_precharge_done, ss_ramp_above_fb, phase_a_hs_pulse, ss_ramp_done} = 4'h0;
      // the last pass drops enable mid-hiccup to prove the abort path
      if (i == 5) en_pull_low = 1;
      if (i == 4) begin
        cyc(80);
        `CHK("input_overvolt_lockout_wait", 3'h4, seq_state)
        vin_above_input_overvolt_lockout_rise = 0;
        vin_below_input_overvolt_lockout_fall = 1;
      end else if (i < 5) begin
        n = 0;
        while (seq_state === 3'h4 && n < 99) begin
          cyc(1);
          n++;
        end
        `CHK("hic", 1'b1, hic_n >= (fl == 2'h1 ? 40 : fl == 2'h2 ? 30 : 50) && hic_n <= (fl == 2'h1 ? 43 : fl == 2'h2 ? 33 : 53))
      end
      if (i < 5) wst(3'h1);
      if (i[0]) vin_above_input_undervolt_lockout = 0;
      else en_pull_low = 1;
      wst(3'h0);
      `CHK("hiz_off", 1'b1, switches_hiz)
      `CHK("pu3_off", i[0] && i != 5, en_pullup_3ua)
    end
    give_verdict();
  end
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
endmodule
